/* File: design/ssc_pkg.sv */
// shared constants and types for the signalling section classifier
// assumes both ends are compiled after this package
package ssc_pkg;
   // -----------------------------------------------------------------
   // table identifiers
   // -----------------------------------------------------------------
   localparam logic [7:0] TID_RELAY_MAP = 8'h41;
   localparam logic [7:0] TID_SUPERFRAME = 8'hA0;
   localparam logic [7:0] TID_FRAME = 8'hA1;
   localparam logic [7:0] TID_TIMESLOT = 8'hA2;
   localparam logic [7:0] TID_SAT_POS = 8'hA3;
   localparam logic [7:0] TID_CORRECTION = 8'hA4;
   localparam logic [7:0] TID_BURST_PLAN = 8'hA5;
   localparam logic [7:0] TID_CLOCK_REF = 8'hA6;
   localparam logic [7:0] TID_TX_MODE = 8'hAA;
   localparam logic [7:0] TID_TERM_INFO = 8'hB0;
   // -----------------------------------------------------------------
   // section layout
   // -----------------------------------------------------------------
   localparam logic [11:0] SECT_LEN_MAX = 12'h3FD; // 1021
   localparam logic [3:0] SI_HDR_BYTES = 4'h8; // 64 bits
   localparam logic [3:0] DSM_HDR_BYTES = 4'hC; // 96 bits
   localparam logic [3:0] BYTE_SCRAMBLE = 4'h5; // dsm-cc byte with scrambling bits
   localparam logic [12:0] PID_RELAY_MAP_DEF = 13'h0010;
   localparam int BUF_DEPTH = 2;
   // table class handed to consumers
   typedef enum logic [3:0] {
      SSC_CLS_NONE, SSC_CLS_SUPERFRAME, SSC_CLS_FRAME, SSC_CLS_TIMESLOT, SSC_CLS_SAT_POS,
      SSC_CLS_CORRECTION, SSC_CLS_BURST_PLAN, SSC_CLS_CLOCK_REF, SSC_CLS_TX_MODE,
      SSC_CLS_TERM_INFO, SSC_CLS_RELAY_MAP
   } ssc_class_t;
endpackage

/* File: design/ssc_link_if.sv */
// link between the demultiplexer end and the classifier end
// assumes one clock and a byte stream with a start-of-section marker
`timescale 1ns/1ns
`default_nettype none
interface ssc_link_if;
   logic [7:0] data;
   logic [12:0] pid;
   logic sos;
   logic valid;
   logic ready;
   modport demux (output data, output pid, output sos, output valid, input ready);
   modport classifier (input data, input pid, input sos, input valid, output ready);
endinterface
`default_nettype wire

/* File: design/ssc_demux_end.sv */
// demultiplexer end: carries user section bytes onto the link
// assumes the user marks the first byte of each section with a start flag
`timescale 1ns/1ns
`default_nettype none
module ssc_demux_end (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link
   ssc_link_if.demux link,
   // user side
   input wire logic [7:0] usr_data,
   input wire logic [12:0] usr_pid,
   input wire logic usr_sos,
   input wire logic usr_valid,
   output logic usr_ready
);
   import ssc_pkg::*;
   logic [7:0] data_reg;
   logic [12:0] pid_reg;
   logic sos_reg;
   logic valid_reg;
   wire logic take = usr_valid && usr_ready;
   // -----------------------------------------------------------------
   // one-word output stage; sections framed as private sections
   // -----------------------------------------------------------------
   assign usr_ready = !valid_reg || link.ready;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_reg <= 1'b0;
      end else if (usr_ready) begin
         valid_reg <= usr_valid;
      end
   end
   // data held on stall so no byte changes under a waiting receiver
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_reg <= 8'h00;
         pid_reg <= 13'h0000;
         sos_reg <= 1'b0;
      end else if (take) begin
         data_reg <= usr_data;
         pid_reg <= usr_pid;
         sos_reg <= usr_sos;
      end
   end
   // tim carried in dsm-cc sections, per section scrambling bits
   assign link.data = data_reg;
   assign link.pid = pid_reg;
   assign link.sos = sos_reg;
   assign link.valid = valid_reg;
endmodule
`default_nettype wire

/* File: design/ssc_classifier.sv */
// classifier end: tags forward-link signalling sections by table identifier
// assumes byte stream from the demultiplexer end over ssc_link_if
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - 0xA0..0xA2 tag superframe, frame, timeslot tables
// - 0xA3..0xA5 tag position, correction, burst plan
// - 0xA6, 0xB0, 0x41 tag clockref, terminal, relay
// - 0xAA tags transmission mode, own output
// - reserved identifiers never reach any consumer
// - relay map pid and signalling pid both configured
// - sender uses standard private section format
// - terminal messages use dsm-cc header layout
// - scrambled tables handled like ordinary tables
// - scrambling decided per section, not stream
// - burst plan goes to transmit scheduler
// - section length above 1021 is rejected
// - si header is exactly 64 bits
// - dsm-cc header is exactly 96 bits
module ssc_classifier (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link
   ssc_link_if.classifier link,
   // configuration
   input wire logic [12:0] cfg_relay_pid,
   input wire logic [12:0] cfg_sig_pid,
   // section announce
   output ssc_pkg::ssc_class_t sec_class,
   output logic sec_strobe,
   output logic sec_scrambled,
   output logic [11:0] sec_length,
   output logic [47:0] sec_mac,
   // payload stream
   output logic [7:0] pay_data,
   output logic pay_valid,
   input wire logic pay_ready,
   // per-table consumer strobes
   output logic sched_strobe,
   output logic txmode_strobe
);
   import ssc_pkg::*;
   typedef enum {ST_IDLE, ST_HDR, ST_BODY, ST_SKIP} ssc_state_t;
   // -----------------------------------------------------------------
   // two-entry input buffer
   // -----------------------------------------------------------------
   logic [21:0] buf_mem [BUF_DEPTH];
   logic wp_reg, rp_reg;
   logic [1:0] cnt_reg;
   wire logic buf_full = (cnt_reg == 2'(BUF_DEPTH));
   wire logic buf_empty = (cnt_reg == 2'h0);
   wire logic push = link.valid && !buf_full;
   wire logic [21:0] head = buf_mem[rp_reg];
   wire logic [7:0] b_data = head[7:0];
   wire logic [12:0] b_pid = head[20:8];
   wire logic b_sos = head[21];
   logic pop;
   assign link.ready = !buf_full;
   always_ff @(posedge core_clk) begin
      if (push) begin
         buf_mem[wp_reg] <= {link.sos, link.pid, link.data};
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         wp_reg <= wp_reg ^ push;
         rp_reg <= rp_reg ^ pop;
         cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
      end
   end
   // -----------------------------------------------------------------
   // table identifier decode
   // -----------------------------------------------------------------
   function automatic ssc_class_t tid_class(input logic [7:0] tid);
      case (tid)
         TID_SUPERFRAME: tid_class = SSC_CLS_SUPERFRAME;
         TID_FRAME: tid_class = SSC_CLS_FRAME;
         TID_TIMESLOT: tid_class = SSC_CLS_TIMESLOT;
         TID_SAT_POS: tid_class = SSC_CLS_SAT_POS;
         TID_CORRECTION: tid_class = SSC_CLS_CORRECTION;
         TID_BURST_PLAN: tid_class = SSC_CLS_BURST_PLAN;
         TID_CLOCK_REF: tid_class = SSC_CLS_CLOCK_REF;
         TID_TERM_INFO: tid_class = SSC_CLS_TERM_INFO;
         TID_RELAY_MAP: tid_class = SSC_CLS_RELAY_MAP;
         TID_TX_MODE: tid_class = SSC_CLS_TX_MODE;
         default: tid_class = SSC_CLS_NONE; // reserved codes
      endcase
   endfunction
   // -----------------------------------------------------------------
   // header walk state
   // -----------------------------------------------------------------
   ssc_state_t state_reg, state_next;
   ssc_class_t cls_reg;
   logic [3:0] hcnt_reg;
   logic [11:0] len_reg, left_reg;
   logic scr_reg;
   logic [47:0] mac_reg;
   logic [7:0] pay_reg;
   logic pay_v_reg, strobe_reg;
   wire logic pay_free = !pay_v_reg || pay_ready;
   wire logic have = !buf_empty;
   wire logic start = have && b_sos;
   // relay pid admits only the relay map; the configured pid admits all tables, relay map included
   wire logic pid_ok = (b_pid == cfg_relay_pid) ? (b_data == TID_RELAY_MAP)
                       : (b_pid == cfg_sig_pid);
   wire logic is_dsm = (cls_reg == SSC_CLS_TERM_INFO);
   wire logic [3:0] hdr_bytes = is_dsm ? DSM_HDR_BYTES : SI_HDR_BYTES;
   wire logic [11:0] len_full = {len_reg[11:8], b_data};
   wire logic len_bad = (hcnt_reg == 4'h2) && (len_full > SECT_LEN_MAX);
   wire logic hdr_last = (hcnt_reg == hdr_bytes - 4'h1);
   wire logic body_last = (left_reg == 12'h001);
   // body bytes wait for the payload stage, others drain freely
   assign pop = have && (state_reg != ST_BODY || pay_free || b_sos);
   // next-state selection; a start byte always restarts the walk
   always_comb begin
      state_next = state_reg;
      if (pop) begin
         case (state_reg)
            ST_IDLE, ST_SKIP: state_next = ST_IDLE;
            ST_HDR: state_next = len_bad ? ST_SKIP : (hdr_last ? ST_BODY : ST_HDR);
            ST_BODY: state_next = body_last ? ST_IDLE : ST_BODY;
            default: state_next = ST_IDLE;
         endcase
         if (state_reg == ST_SKIP && !b_sos) state_next = ST_SKIP;
         if (state_reg == ST_IDLE && !b_sos) state_next = ST_IDLE;
         if (start) begin
            state_next = (pid_ok && tid_class(b_data) != SSC_CLS_NONE) ? ST_HDR : ST_SKIP;
         end
      end
   end
   // reset discards any section in progress
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) state_reg <= ST_IDLE;
      else state_reg <= state_next;
   end
   // header field capture
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cls_reg <= SSC_CLS_NONE;
         hcnt_reg <= 4'h0;
         len_reg <= 12'h000;
         left_reg <= 12'h000;
         scr_reg <= 1'b0;
         mac_reg <= 48'h0;
      end else if (pop) begin
         hcnt_reg <= start ? 4'h1 : hcnt_reg + 4'h1;
         if (start) begin
            cls_reg <= tid_class(b_data);
            scr_reg <= 1'b0;
         end
         if (state_reg == ST_HDR && hcnt_reg == 4'h1) len_reg <= {b_data[3:0], 8'h00};
         if (state_reg == ST_HDR && hcnt_reg == 4'h2) len_reg <= len_full;
         // bytes left after the header, counted from after the length field
         if (state_reg == ST_HDR && hdr_last) left_reg <= len_reg - 12'(hdr_bytes - 4'h3);
         if (state_reg == ST_BODY) left_reg <= left_reg - 12'h001;
         // scrambling state taken per section from its own header
         if (state_reg == ST_HDR && is_dsm && hcnt_reg == BYTE_SCRAMBLE)
            scr_reg <= |b_data[5:2];
         if (state_reg == ST_HDR && !is_dsm && hcnt_reg == 4'h1) scr_reg <= 1'b0;
         // mac bytes arrive 6,5 then 4..1; later bytes shift in from the top
         if (state_reg == ST_HDR && is_dsm && hcnt_reg == 4'h3) mac_reg[7:0] <= b_data;
         if (state_reg == ST_HDR && is_dsm && hcnt_reg == 4'h4) mac_reg[15:8] <= b_data;
         if (state_reg == ST_HDR && is_dsm && hcnt_reg >= 4'h8)
            mac_reg[47:16] <= {b_data, mac_reg[47:24]};
      end
   end
   // announce strobe fires once, as the header completes
   wire logic announce = pop && state_reg == ST_HDR && hdr_last && !len_bad;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) strobe_reg <= 1'b0;
      else strobe_reg <= announce;
   end
   // payload stage, one entry; a restart mid-section drops the rest
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pay_v_reg <= 1'b0;
         pay_reg <= 8'h00;
      end else if (pay_free) begin
         pay_v_reg <= pop && state_reg == ST_BODY && !b_sos;
         pay_reg <= b_data;
      end
   end
   assign sec_class = cls_reg;
   assign sec_strobe = strobe_reg;
   assign sec_scrambled = scr_reg;
   assign sec_length = len_reg;
   assign sec_mac = mac_reg;
   assign pay_data = pay_reg;
   assign pay_valid = pay_v_reg;
   assign sched_strobe = strobe_reg && cls_reg == SSC_CLS_BURST_PLAN;
   assign txmode_strobe = strobe_reg && cls_reg == SSC_CLS_TX_MODE;
endmodule
`default_nettype wire

/* File: tb/ssc_link_props.sv */
// checker for the classifier link and its announce outputs
// assumes one clock; placed beside the link in the bench
`timescale 1ns/1ns
`default_nettype none
module ssc_link_props
   import ssc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link
   input wire logic [7:0] data,
   input wire logic sos,
   input wire logic valid,
   input wire logic ready,
   // classifier outputs
   input wire ssc_pkg::ssc_class_t sec_class,
   input wire logic sec_strobe,
   input wire logic sec_scrambled,
   input wire logic [11:0] sec_length,
   input wire logic [7:0] pay_data,
   input wire logic pay_valid,
   input wire logic pay_ready,
   input wire logic sched_strobe,
   input wire logic txmode_strobe
);
   import ssc_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // -----------------------------------------------------------------
   // properties: a header spans at least eight bytes, so strobes are spaced
   // -----------------------------------------------------------------
   a_strobe_gap: assert property (
      sec_strobe |=> !sec_strobe [*7]) else $error("announce strobes too close");
   a_class_known: assert property (
      sec_strobe |-> sec_class != SSC_CLS_NONE) else $error("strobe without class");
   a_sched_plan: assert property (
      sched_strobe |-> sec_strobe && sec_class == SSC_CLS_BURST_PLAN) else $error("bad sched");
   a_txmode_out: assert property (
      txmode_strobe |-> sec_strobe && sec_class == SSC_CLS_TX_MODE) else $error("bad txmode");
   a_length_cap: assert property (
      sec_strobe |-> sec_length <= SECT_LEN_MAX) else $error("long section announced");
   a_si_clear: assert property (
      sec_strobe && sec_class != SSC_CLS_TERM_INFO |-> !sec_scrambled) else $error("si scrambled");
   a_pay_hold: assert property (
      pay_valid && !pay_ready |=> pay_valid && $stable(pay_data)) else $error("payload dropped");
   a_link_hold: assert property (
      valid && !ready |=> valid && $stable(data) && $stable(sos)) else $error("link byte dropped");
endmodule
`default_nettype wire

/* File: tb/signalling_section_classifier_tb_top.sv */
// bench for both ends of the classifier joined by the link
// assumes the package, link and both ends are compiled first
`timescale 1ns/1ns
`default_nettype none
module signalling_section_classifier_tb_top;
   import ssc_pkg::*;
   localparam logic [12:0] SPID = 13'h0100;
   localparam logic [7:0] KT [10] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hAA,
      8'hB0, 8'h41};
   localparam logic [7:0] RT [7] = '{8'hA7, 8'hA8, 8'hA9, 8'hAB, 8'hAF, 8'hB1, 8'hBF};
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] usr_data = 8'h00;
   logic [12:0] usr_pid = 13'h0000;
   logic usr_sos = 1'b0;
   logic usr_valid = 1'b0;
   logic pay_ready = 1'b1;
   logic usr_ready, sec_strobe, sec_scrambled, pay_valid, sched_strobe, txmode_strobe;
   ssc_class_t sec_class;
   logic [11:0] sec_length;
   logic [47:0] sec_mac;
   logic [7:0] pay_data, last_pay;
   int err_count = 0;
   int n_checks = 0;
   int n_str = 0, n_pay = 0, n_sch = 0, n_tx = 0, exp_pay = 0;
   ssc_link_if link ();
   ssc_demux_end ssc_demux_end_i (.core_clk(core_clk), .rst_n(rst_n), .link(link.demux),
      .usr_data(usr_data), .usr_pid(usr_pid), .usr_sos(usr_sos), .usr_valid(usr_valid),
      .usr_ready(usr_ready));
   ssc_classifier ssc_classifier_i (.core_clk(core_clk), .rst_n(rst_n),
      .link(link.classifier), .cfg_relay_pid(PID_RELAY_MAP_DEF), .cfg_sig_pid(SPID),
      .sec_class(sec_class), .sec_strobe(sec_strobe), .sec_scrambled(sec_scrambled),
      .sec_length(sec_length), .sec_mac(sec_mac), .pay_data(pay_data), .pay_valid(pay_valid),
      .pay_ready(pay_ready), .sched_strobe(sched_strobe), .txmode_strobe(txmode_strobe));
   ssc_link_props ssc_link_props_i (.core_clk(core_clk), .rst_n(rst_n), .data(link.data),
      .sos(link.sos), .valid(link.valid), .ready(link.ready), .sec_class(sec_class),
      .sec_strobe(sec_strobe), .sec_scrambled(sec_scrambled), .sec_length(sec_length),
      .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready),
      .sched_strobe(sched_strobe), .txmode_strobe(txmode_strobe));
   // 250 MHz clock
   always #2 core_clk = ~core_clk;
   // count announces and payload bytes as the consumers see them
   always @(posedge core_clk) begin
      if (sec_strobe === 1'b1) n_str <= n_str + 1;
      if (sched_strobe === 1'b1) n_sch <= n_sch + 1;
      if (txmode_strobe === 1'b1) n_tx <= n_tx + 1;
      if (pay_valid === 1'b1 && pay_ready) n_pay <= n_pay + 1;
      if (pay_valid === 1'b1 && pay_ready) last_pay <= pay_data;
   end
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   function automatic logic [7:0] hb(int i, logic [7:0] t, logic [11:0] len, logic scr);
      case (i)
         0: return t;
         1: return {4'hB, len[11:8]};
         2: return len[7:0];
         5: return scr ? 8'h15 : 8'hC3;
         default: return 8'h10 + 8'(i);
      endcase
   endfunction
   // one byte held until the link takes it; bounded so a hang ends the run
   task automatic put(input logic [7:0] b, input logic [12:0] p, input logic s);
      int k;
      @(negedge core_clk);
      usr_data = b;
      usr_pid = p;
      usr_sos = s;
      usr_valid = 1'b1;
      for (k = 0; usr_ready !== 1'b1 && k < 300; k++) @(negedge core_clk);
      if (k == 300) begin
         err_count++;
         final_report();
      end
      @(posedge core_clk);
   endtask
   // a whole section; an over-long one is cut after its header
   task automatic sect(string nm, logic [7:0] t, logic [12:0] p, logic [11:0] len, logic scr,
         ssc_class_t exp);
      int hdr, n0, k;
      hdr = (t == TID_TERM_INFO) ? 12 : 8;
      n0 = n_str;
      for (int i = 0; i < ((len > SECT_LEN_MAX) ? hdr : len + 3); i++) put(hb(i, t, len, scr),
         p, i == 0);
      @(negedge core_clk);
      usr_valid = 1'b0;
      for (k = 0; n_str == n0 && k < 40; k++) @(negedge core_clk);
      chk({nm, " strobes"}, (exp == SSC_CLS_NONE) ? 0 : 1, n_str - n0);
      if (exp != SSC_CLS_NONE) begin
         chk({nm, " class"}, exp, sec_class);
         exp_pay += len + 3 - hdr;
      end
      $display("test %s done", nm);
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   initial begin
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      foreach (KT[i]) sect("known", KT[i], SPID, 12'h00B, 1'b0, ssc_class_t'(i + 1));
      sect("relay", TID_RELAY_MAP, PID_RELAY_MAP_DEF, 12'h00B, 1'b0, SSC_CLS_RELAY_MAP);
      sect("relay pid", TID_FRAME, PID_RELAY_MAP_DEF, 12'h00B, 1'b0, SSC_CLS_NONE);
      sect("other pid", TID_FRAME, 13'h0123, 12'h00B, 1'b0, SSC_CLS_NONE);
      foreach (RT[i]) sect("reserved", RT[i], SPID, 12'h00B, 1'b0, SSC_CLS_NONE);
      sect("limit", TID_TIMESLOT, SPID, SECT_LEN_MAX, 1'b0, SSC_CLS_TIMESLOT);
      chk("length", SECT_LEN_MAX, sec_length);
      sect("too long", TID_TIMESLOT, SPID, 12'h3FE, 1'b0, SSC_CLS_NONE);
      sect("dsm scrambled", TID_TERM_INFO, SPID, 12'h00B, 1'b1, SSC_CLS_TERM_INFO);
      chk("scrambled", 1, sec_scrambled);
      chk("mac", 48'h1B1A19181413, sec_mac);
      sect("dsm clear", TID_TERM_INFO, SPID, 12'h00B, 1'b0, SSC_CLS_TERM_INFO);
      chk("clear", 0, sec_scrambled);
      // consumer stalls while a section streams in; nothing may be lost
      pay_ready = 1'b0;
      fork
         sect("stall", TID_SAT_POS, SPID, 12'h00B, 1'b0, SSC_CLS_SAT_POS);
         begin
            repeat (30) @(negedge core_clk);
            pay_ready = 1'b1;
         end
      join
      // reset in mid-header drops the partial section
      put(TID_SUPERFRAME, SPID, 1'b1);
      put(8'hB0, SPID, 1'b0);
      @(negedge core_clk);
      usr_valid = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      sect("after reset", TID_FRAME, SPID, 12'h00B, 1'b0, SSC_CLS_FRAME);
      repeat (20) @(negedge core_clk);
      chk("payload", exp_pay, n_pay);
      chk("last payload", 8'h1D, last_pay);
      chk("sched", 1, n_sch);
      chk("txmode", 1, n_tx);
      final_report();
   end
endmodule
`default_nettype wire
